// [hw/ahs_homing_seq.sv]
// Behaviour
// R1 - Per-axis flag: homing required, default yes
// R2 - Program start blocked until required axes referenced
// R3 - Reset aborts homing, leaves unreferenced, flags error
// R4 - Per-axis referenced status output
// R5 - Overwrite position with known value at point
// R6 - Per-axis select cam or no cam homing
// R7 - With cam: cam, zero pulse, reference point
// R8 - Host routes cam input onto cam signal
// R9 - Without cam: zero pulse then reference point
// R10 - Direction setting; start only on matching key
// R11 - Before cam: fast; on cam: creep reverse
// R12 - Never start beyond the cam
// R13 - Marker side setting steers synchronisation search
// R14 - After pulse travel offset to reference point
// R15 - Load reference coordinate at reference point
// R16 - Error when cam search distance exceeded
// R17 - Error when marker search distance exceeded
// R18 - Marker search distance below marker spacing
// R19 - Cam long enough to stop on
// R20 - Referencing velocity to cam, creep to pulse
// R21 - Approach velocity from sync to reference point
// R22 - Marker search ignores override; zero cancels
// R23 - Referenced cleared at reset, set at end
`timescale 1ns/1ps
module ahs_homing_seq
   import ahs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ahs_pins_t host_pins,
   input wire logic [NAXIS-1:0] enc_up,
   input wire logic [NAXIS-1:0] enc_dn,
   output logic [NAXIS-1:0][31:0] vel_cmd,
   output logic [NAXIS-1:0] referenced,
   output logic [NAXIS-1:0] homing_err,
   output logic prog_start_ok,
   output logic prog_start_grant,
   output logic prog_start_refused
);

   // ==========================================================
   // Reset release and pin synchronisers
   logic [1:0] rst_sr_q;
   logic rst_n;
   ahs_pins_t pin_s1_q, pin_s2_q;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sr_q <= 2'h0;
      end else begin
         rst_sr_q <= {rst_sr_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sr_q[1];
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= host_pins;
         pin_s2_q <= pin_s1_q;
      end
   end
   // ==========================================================
   // APB register file
   ahs_cfg_t cfg_q, cfg_d;
   logic [31:0] rdata_q, rdata_d;
   logic err_q, err_d;
   logic [NAXIS-1:0][31:0] pos_w;
   logic [NAXIS-1:0] busy_w;
   logic [31:0] status_w;
   logic wr_en;
   assign wr_en = psel && penable && pwrite && !err_q;
   assign status_w = 32'({prog_start_ok, busy_w, homing_err, referenced});
   always_comb begin
      cfg_d = cfg_q;
      rdata_d = rdata_q;
      err_d = err_q;
      if (wr_en) begin
         case (paddr)
            REG_CTRL: cfg_d.ctrl = pwdata;
            REG_AXCFG: cfg_d.axcfg = pwdata;
            REG_VREF: cfg_d.vref = pwdata;
            REG_VCREEP: cfg_d.vcreep = pwdata;
            REG_VAPPR: cfg_d.vappr = pwdata;
            REG_OFFSET: cfg_d.offs = pwdata;
            REG_COORD: cfg_d.coord = pwdata;
            REG_MAXCAM: cfg_d.maxcam = pwdata;
            REG_MAXMARK: cfg_d.maxmark = pwdata;
            default: cfg_d = cfg_q;
         endcase
      end
      // Decode in the setup cycle so the answer comes from flops
      if (psel && !penable) begin
         err_d = 1'b0;
         rdata_d = 32'h0000_0000;
         case (paddr)
            REG_CTRL: rdata_d = cfg_q.ctrl;
            REG_AXCFG: rdata_d = cfg_q.axcfg;
            REG_VREF: rdata_d = cfg_q.vref;
            REG_VCREEP: rdata_d = cfg_q.vcreep;
            REG_VAPPR: rdata_d = cfg_q.vappr;
            REG_OFFSET: rdata_d = cfg_q.offs;
            REG_COORD: rdata_d = cfg_q.coord;
            REG_MAXCAM: rdata_d = cfg_q.maxcam;
            REG_MAXMARK: rdata_d = cfg_q.maxmark;
            REG_STATUS: rdata_d = status_w;
            default: err_d = 1'b1;
         endcase
         for (int i = 0; i < NAXIS; i++) begin
            if (paddr == REG_POS0 + AW'(i) * POS_STRIDE) begin
               rdata_d = pos_w[i];
               err_d = 1'b0;
            end
         end
         if (pwrite && (paddr == REG_STATUS || paddr >= REG_POS0)) begin
            err_d = 1'b1;
         end
         if (err_d) begin
            rdata_d = 32'h0000_0000;
         end
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CFG_RST;
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
      end
   end
   assign pready = 1'b1;
   assign prdata = rdata_q;
   assign pslverr = psel && penable && err_q;
   // ==========================================================
   // Program start gate
   logic nc_start_q, grant_q, grant_d, refuse_q, refuse_d;
   logic start_edge;
   // Axes not flagged as needing homing never block the start
   always_comb begin
      prog_start_ok = cfg_q.ctrl[CTRL_ALLOW_BIT]; // R2
      if (!prog_start_ok) begin
         prog_start_ok = 1'b1;
         for (int i = 0; i < NAXIS; i++) begin
            if (cfg_q.axcfg[i*AXCFG_W] && !referenced[i]) begin // R1
               prog_start_ok = 1'b0;
            end
         end
      end
   end

   assign start_edge = pin_s2_q.nc_start && !nc_start_q;
   always_comb begin
      grant_d = start_edge && prog_start_ok; // R2
      refuse_d = start_edge && !prog_start_ok;
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         nc_start_q <= 1'b0;
         grant_q <= 1'b0;
         refuse_q <= 1'b0;
      end else begin
         nc_start_q <= pin_s2_q.nc_start;
         grant_q <= grant_d;
         refuse_q <= refuse_d;
      end
   end
   assign prog_start_grant = grant_q;
   assign prog_start_refused = refuse_q;

   // ==========================================================
   // Per-axis homing sequencer
   for (genvar a = 0; a < NAXIS; a++) begin : g_ax
      ahs_state_t st_q, st_d;
      ahs_axcfg_t c;
      logic signed [31:0] pos_q, pos_d, vel_q, vel_d, tgt_q, tgt_d, diff;
      logic [31:0] dist_q, dist_d, mag;
      logic ref_q, ref_d, err_q, err_d, rev_q, rev_d;
      logic key_q, zero_q, key_now, cam, zero_edge, ovr_zero, hold, active;
      assign c = cfg_q.axcfg[a*AXCFG_W +: AXCFG_W];
      assign key_now = c.dir_minus ? pin_s2_q.key_minus[a] : pin_s2_q.key_plus[a]; // R10
      assign cam = pin_s2_q.reference_cam[a]; // R8
      assign zero_edge = pin_s2_q.zero_pulse[a] && !zero_q;
      assign ovr_zero = pin_s2_q.override_pct == OVR_ZERO;
      assign hold = ovr_zero || pin_s2_q.feed_hold;
      assign active = !(st_q inside {ST_IDLE, ST_DONE, ST_ERR});
      assign diff = tgt_q - pos_q;
      always_comb begin
         st_d = st_q;
         pos_d = pos_q;
         tgt_d = tgt_q;
         dist_d = dist_q;
         ref_d = ref_q;
         err_d = err_q;
         rev_d = rev_q;
         mag = 32'h0000_0000;
         if (enc_up[a]) begin
            pos_d = pos_q + 32'sd1;
         end else if (enc_dn[a]) begin
            pos_d = pos_q - 32'sd1;
         end
         if (enc_up[a] != enc_dn[a]) begin
            dist_d = dist_q + 32'h0000_0001;
         end
         case (st_q)
            ST_IDLE, ST_DONE, ST_ERR: begin
               // Caller must not start beyond the cam
               if (pin_s2_q.mode_home && key_now && !key_q) begin // R10 R12
                  ref_d = 1'b0;
                  err_d = 1'b0;
                  dist_d = 32'h0000_0000;
                  rev_d = 1'b0;
                  if (!c.with_cam) begin
                     st_d = ST_SYNC; // R6 R9
                  end else if (cam) begin
                     st_d = ST_LEAVE; // R11
                     rev_d = 1'b1;
                  end else begin
                     st_d = ST_TO_CAM; // R7 R11
                  end
               end
            end
            ST_TO_CAM: begin
               mag = hold ? 32'h0000_0000 : cfg_q.vref; // R20
               if (dist_q > cfg_q.maxcam) begin
                  st_d = ST_ERR; // R16
                  err_d = 1'b1;
               end else if (cam) begin
                  dist_d = 32'h0000_0000;
                  if (c.marker_behind) begin
                     st_d = ST_SYNC; // R13
                  end else begin
                     st_d = ST_LEAVE; // R13
                     rev_d = 1'b1;
                  end
               end
            end
            ST_LEAVE: begin
               mag = hold ? 32'h0000_0000 : cfg_q.vcreep; // R11
               if (!cam) begin
                  dist_d = 32'h0000_0000;
                  if (c.marker_behind) begin
                     st_d = ST_TO_CAM; // R13
                     rev_d = 1'b0;
                  end else begin
                     st_d = ST_SYNC; // R7
                  end
               end
            end
            ST_SYNC: begin
               // Override is ignored here, only zero or hold cancels
               mag = cfg_q.vcreep; // R20 R22
               if (hold || dist_q > cfg_q.maxmark) begin
                  st_d = ST_ERR; // R17 R22
                  err_d = 1'b1;
               end else if (zero_edge) begin
                  st_d = ST_TO_REF; // R14
                  tgt_d = c.dir_minus ? pos_q - cfg_q.offs : pos_q + cfg_q.offs; // R14
               end
            end
            ST_TO_REF: begin
               if (diff == 32'sd0) begin
                  st_d = ST_DONE;
                  pos_d = cfg_q.coord; // R5 R15
                  ref_d = 1'b1; // R23
               end else begin
                  mag = hold ? 32'h0000_0000 : cfg_q.vappr; // R21
               end
            end
            default: begin
               st_d = ST_IDLE;
            end
         endcase
         if (pin_s2_q.nc_reset && active) begin
            st_d = ST_ERR; // R3
            err_d = 1'b1;
            ref_d = 1'b0;
            mag = 32'h0000_0000;
         end
         // Sign: toward the target in ST_TO_REF, else defined direction, reversed when leaving the cam
         if (st_q == ST_TO_REF) begin
            vel_d = diff < 32'sd0 ? -$signed(mag) : $signed(mag);
         end else begin
            vel_d = (c.dir_minus ^ rev_q) ? -$signed(mag) : $signed(mag);
         end
         if (st_d != st_q && (st_d == ST_ERR || st_d == ST_DONE)) begin
            vel_d = 32'sd0;
         end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            st_q <= ST_IDLE;
            pos_q <= 32'sd0;
            tgt_q <= 32'sd0;
            vel_q <= 32'sd0;
            dist_q <= 32'h0000_0000;
            ref_q <= 1'b0; // R23
            err_q <= 1'b0;
            rev_q <= 1'b0;
            key_q <= 1'b0;
            zero_q <= 1'b0;
         end else begin
            st_q <= st_d;
            pos_q <= pos_d;
            tgt_q <= tgt_d;
            vel_q <= vel_d;
            dist_q <= dist_d;
            ref_q <= ref_d;
            err_q <= err_d;
            rev_q <= rev_d;
            key_q <= key_now;
            zero_q <= pin_s2_q.zero_pulse[a];
         end
      end

      assign vel_cmd[a] = vel_q;
      assign referenced[a] = ref_q; // R4
      assign homing_err[a] = err_q;
      assign pos_w[a] = pos_q;
      assign busy_w[a] = active;
   end

endmodule

// [hw/ahs_pkg.sv]
package ahs_pkg;

   // ==========================================================
   // Sizes
   localparam int NAXIS = 4;
   localparam int AW = 8;
   localparam int OVR_W = 7;

   // ==========================================================
   // Register byte offsets
   localparam logic [AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AW-1:0] REG_AXCFG = 8'h04;
   localparam logic [AW-1:0] REG_VREF = 8'h08;
   localparam logic [AW-1:0] REG_VCREEP = 8'h0C;
   localparam logic [AW-1:0] REG_VAPPR = 8'h10;
   localparam logic [AW-1:0] REG_OFFSET = 8'h14;
   localparam logic [AW-1:0] REG_COORD = 8'h18;
   localparam logic [AW-1:0] REG_MAXCAM = 8'h1C;
   localparam logic [AW-1:0] REG_MAXMARK = 8'h20;
   localparam logic [AW-1:0] REG_STATUS = 8'h24;
   localparam logic [AW-1:0] REG_POS0 = 8'h40;
   localparam logic [AW-1:0] POS_STRIDE = 8'h04;

   // ==========================================================
   // Field layout
   localparam int CTRL_ALLOW_BIT = 0;
   localparam int AXCFG_W = 4;

   // Per-axis configuration nibble, axis a at bits [4a+3:4a]
   typedef struct packed {
      logic marker_behind;
      logic dir_minus;
      logic with_cam;
      logic need_ref;
   } ahs_axcfg_t;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] axcfg;
      logic [31:0] vref;
      logic [31:0] vcreep;
      logic [31:0] vappr;
      logic [31:0] offs;
      logic [31:0] coord;
      logic [31:0] maxcam;
      logic [31:0] maxmark;
   } ahs_cfg_t;

   // ==========================================================
   // Reset values
   localparam ahs_cfg_t CFG_RST = '{
      ctrl: 32'h0000_0000,
      axcfg: 32'h0000_3333,
      vref: 32'h0000_1388,
      vcreep: 32'h0000_012C,
      vappr: 32'h0000_03E8,
      offs: 32'hFFFF_FFFE,
      coord: 32'h0000_0000,
      maxcam: 32'h0000_2710,
      maxmark: 32'h0000_0014
   };

   // ==========================================================
   // Host-side pins, all asynchronous to ref_clk
   typedef struct packed {
      logic mode_home;
      logic nc_reset;
      logic nc_start;
      logic feed_hold;
      logic [OVR_W-1:0] override_pct;
      logic [NAXIS-1:0] key_plus;
      logic [NAXIS-1:0] key_minus;
      logic [NAXIS-1:0] reference_cam;
      logic [NAXIS-1:0] zero_pulse;
   } ahs_pins_t;

   localparam logic [OVR_W-1:0] OVR_ZERO = 7'h00;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_TO_CAM = 7'h02,
      ST_LEAVE = 7'h04,
      ST_SYNC = 7'h08,
      ST_TO_REF = 7'h10,
      ST_DONE = 7'h20,
      ST_ERR = 7'h40
   } ahs_state_t;

endpackage

// [test/ahs_axis_model.sv]
`timescale 1ns/1ps
module ahs_axis_model
   import ahs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [NAXIS-1:0][31:0] vel_cmd,
   input wire logic slow,
   input wire logic signed [31:0] cam_at,
   input wire logic signed [31:0] start_pos,
   output logic [NAXIS-1:0] enc_up,
   output logic [NAXIS-1:0] enc_dn,
   output logic [NAXIS-1:0] cam,
   output logic [NAXIS-1:0] zero
);
   // ==========
   // Mechanics
   logic signed [31:0] pos_q [NAXIS];
   logic ph_q;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_q <= 1'b0;
         for (int a = 0; a < NAXIS; a++) pos_q[a] <= start_pos;
      end else begin
         ph_q <= ~ph_q;
         for (int a = 0; a < NAXIS; a++) pos_q[a] <= pos_q[a] + 32'(enc_up[a]) - 32'(enc_dn[a]);
      end
   end

   // Slow drive steps every other cycle only
   always_comb begin
      for (int a = 0; a < NAXIS; a++) begin
         enc_up[a] = ($signed(vel_cmd[a]) > 0) && (!slow || ph_q);
         enc_dn[a] = ($signed(vel_cmd[a]) < 0) && (!slow || ph_q);
         cam[a] = pos_q[a] >= cam_at;
         zero[a] = pos_q[a][5:0] == 6'h0A;
      end
   end
endmodule

// [test/ahs_homing_seq_monitor.sv]
`timescale 1ns/1ps
module ahs_homing_seq_monitor
   import ahs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire ahs_pins_t host_pins,
   input wire logic [NAXIS-1:0][31:0] vel_cmd,
   input wire logic [NAXIS-1:0] referenced,
   input wire logic [NAXIS-1:0] homing_err,
   input wire logic prog_start_ok,
   input wire logic prog_start_grant,
   input wire logic prog_start_refused
);
   // ==========
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   chk_pulse_excl: assert property (!(prog_start_grant && prog_start_refused))
      else $error("grant and refusal in one cycle");
   chk_grant_ok: assert property (prog_start_grant |-> $past(prog_start_ok))
      else $error("grant while start not allowed");
   chk_refuse_ok: assert property (prog_start_refused |-> !$past(prog_start_ok))
      else $error("refusal while start allowed");
   chk_grant_once: assert property (prog_start_grant |=> !prog_start_grant)
      else $error("grant longer than one cycle");
   chk_ref_err_excl: assert property ((referenced & homing_err) == '0)
      else $error("axis referenced and in error");
   chk_err_halt: assert property (homing_err[0] |-> vel_cmd[0] == '0)
      else $error("axis moves while in error");
   chk_ref_halt: assert property (referenced[0] |-> vel_cmd[0] == '0)
      else $error("axis moves while referenced");
   chk_ref_after_move: assert property ($rose(referenced[0]) |-> $past(vel_cmd[0]) != '0)
      else $error("referenced without final travel");
   // Pin passes two flops, then state and output registers
   chk_abort_err: assert property ($rose(host_pins.nc_reset) && vel_cmd[0] != '0
      |-> ##[1:6] homing_err[0] && !referenced[0])
      else $error("abort left axis without error");

   cover property ($rose(referenced[0]));
   cover property ($rose(homing_err[0]));
   cover property (prog_start_grant);
   cover property (prog_start_refused);
endmodule

bind ahs_homing_seq ahs_homing_seq_monitor ahs_homing_seq_monitor_i (
   .ref_clk(ref_clk), .arst_n(arst_n), .host_pins(host_pins), .vel_cmd(vel_cmd),
   .referenced(referenced), .homing_err(homing_err), .prog_start_ok(prog_start_ok),
   .prog_start_grant(prog_start_grant), .prog_start_refused(prog_start_refused)
);

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench
   import ahs_pkg::*;
;
   typedef struct packed {
      logic [31:0] axcfg;
      logic [31:0] cam_at;
      logic [31:0] start;
      logic [31:0] maxcam;
      logic [31:0] v0;
      logic ok;
   } ahs_row_t;

   // ==========
   // Cases: config, cam, start, cam limit, first velocity, success
   ahs_row_t rows [7] = '{
      '{32'h0000_3333, 32'h0000_0096, 32'h0000_0000, 32'h0000_2710, 32'h0000_1388, 1'b1},
      '{32'h0000_333B, 32'h0000_00BE, 32'h0000_0000, 32'h0000_2710, 32'h0000_1388, 1'b1},
      '{32'h0000_3331, 32'h7FFF_FFFF, 32'h0000_0000, 32'h0000_2710, 32'h0000_012C, 1'b1},
      '{32'h0000_3335, 32'h7FFF_FFFF, 32'h0000_0014, 32'h0000_2710, 32'hFFFF_FED4, 1'b1},
      '{32'h0000_3333, 32'h0000_0096, 32'h0000_0000, 32'h0000_0032, 32'h0000_1388, 1'b0},
      '{32'h0000_3333, 32'hFFFF_FF9C, 32'h0000_0000, 32'h0000_2710, 32'hFFFF_FED4, 1'b1},
      '{32'h0000_3331, 32'h7FFF_FFFF, 32'h0000_001E, 32'h0000_2710, 32'h0000_012C, 1'b0}};

   logic ref_clk;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic ncr = 1'b0;
   logic ncs = 1'b0;
   logic slow = 1'b0;
   logic mode = 1'b1;
   logic [OVR_W-1:0] ovr = 7'h64;
   logic [NAXIS-1:0] kp = '0;
   logic [NAXIS-1:0] km = '0;
   logic [31:0] cam_at = '0;
   logic [31:0] start_pos = '0;
   logic [31:0] prdata;
   logic pready, pslverr, grant, refused;
   logic [NAXIS-1:0] cam, zp, enc_up, enc_dn, referenced, homing_err;
   logic [NAXIS-1:0][31:0] vel_cmd;
   ahs_pins_t pins;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;

   assign pins = '{mode_home: mode, nc_reset: ncr, nc_start: ncs, feed_hold: 1'b0,
      override_pct: ovr, key_plus: kp, key_minus: km, reference_cam: cam, zero_pulse: zp};

   ahs_homing_seq ahs_homing_seq_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .host_pins(pins), .enc_up(enc_up), .enc_dn(enc_dn), .vel_cmd(vel_cmd),
      .referenced(referenced), .homing_err(homing_err), .prog_start_ok(),
      .prog_start_grant(grant), .prog_start_refused(refused));

   ahs_axis_model ahs_axis_model_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .vel_cmd(vel_cmd), .slow(slow), .cam_at(cam_at),
      .start_pos(start_pos), .enc_up(enc_up), .enc_dn(enc_dn), .cam(cam), .zero(zp));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // ==========
   // Tasks
   task automatic wrap_up();
      if (mismatches == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic er);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic reset_dut();
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic press(input logic minus);
      @(posedge ref_clk);
      kp[0] <= !minus;
      km[0] <= minus;
      repeat (4) @(posedge ref_clk);
      kp <= '0;
      km <= '0;
   endtask

   task automatic start_prog(output logic [31:0] seen);
      seen = '0;
      @(posedge ref_clk);
      ncs <= 1'b1;
      repeat (8) begin
         @(negedge ref_clk);
         seen = seen | {30'd0, grant, refused};
      end
      @(posedge ref_clk);
      ncs <= 1'b0;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ==========
   // Sequence
   initial begin
      logic [31:0] rd;
      logic er;
      logic appr;
      for (int r = 0; r < 7; r++) begin
         slow <= r[0];
         cam_at <= rows[r].cam_at;
         start_pos <= rows[r].start;
         reset_dut();
         apb(1'b1, REG_AXCFG, rows[r].axcfg, rd, er);
         apb(1'b1, REG_MAXCAM, rows[r].maxcam, rd, er);
         apb(1'b1, REG_COORD, 32'h0000_0064, rd, er);
         press(rows[r].axcfg[2]);
         for (int n = 0; n < 40 && vel_cmd[0] === '0; n++) @(negedge ref_clk);
         chk("first_vel", rows[r].v0, vel_cmd[0]);
         appr = 1'b0;
         for (int n = 0; n < 3000 && (referenced[0] | homing_err[0]) !== 1'b1; n++) begin
            @(negedge ref_clk);
            if (vel_cmd[0] === 32'h0000_03E8 || vel_cmd[0] === 32'hFFFF_FC18) appr = 1'b1;
         end
         chk("referenced", 32'(rows[r].ok), 32'(referenced[0]));
         chk("homing_err", 32'(!rows[r].ok), 32'(homing_err[0]));
         chk("end_vel", 32'h0000_0000, vel_cmd[0]);
         chk("appr_vel", 32'(rows[r].ok), 32'(appr));
         apb(1'b0, REG_POS0, '0, rd, er);
         // Landing may include one increment still in flight
         if (rows[r].ok) chk("pos_near", 32'h1, 32'(rd >= 32'h63 && rd <= 32'h65));
      end
      cam_at <= 32'h7FFF_FFFF;
      start_pos <= '0;
      slow <= 1'b0;
      reset_dut();
      apb(1'b0, REG_STATUS, '0, rd, er);
      chk("status_rst", 32'h0000_0000, rd);
      apb(1'b0, 8'h30, '0, rd, er);
      chk("unmapped", 32'h1, 32'(er));
      press(1'b1);
      repeat (10) @(negedge ref_clk);
      chk("wrong_key", 32'h0000_0000, vel_cmd[0]);
      press(1'b0);
      repeat (20) @(posedge ref_clk);
      ncr <= 1'b1;
      repeat (8) @(negedge ref_clk);
      chk("abort_err", 32'h1, 32'(homing_err[0]));
      chk("abort_ref", 32'h0, 32'(referenced[0]));
      @(posedge ref_clk);
      ncr <= 1'b0;
      start_prog(rd);
      chk("refused", 32'h1, rd);
      apb(1'b1, REG_CTRL, 32'h0000_0001, rd, er);
      start_prog(rd);
      chk("forced", 32'h2, rd);
      apb(1'b1, REG_CTRL, 32'h0000_0000, rd, er);
      apb(1'b1, REG_AXCFG, 32'h0000_2222, rd, er);
      start_prog(rd);
      chk("no_need", 32'h2, rd);
      // Homing mode off: a matching key must not start the axis
      reset_dut();
      apb(1'b1, REG_AXCFG, 32'h0000_3331, rd, er);
      mode <= 1'b0;
      press(1'b0);
      repeat (10) @(negedge ref_clk);
      chk("mode_off", 32'h0000_0000, vel_cmd[0]);
      chk("mode_off_err", 32'h0, 32'(homing_err[0]));
      // Zero override cancels the marker search
      @(posedge ref_clk);
      mode <= 1'b1;
      ovr <= 7'h00;
      press(1'b0);
      repeat (10) @(negedge ref_clk);
      chk("ovr_cancel", 32'h1, 32'(homing_err[0]));
      chk("ovr_vel", 32'h0000_0000, vel_cmd[0]);
      wrap_up();
   end
endmodule
